// >>> csr_params.svh
// Constants for the core status register block
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define CSR_SP_ADDR    8'h81
`define CSR_DPL_ADDR   8'h82
`define CSR_DPH_ADDR   8'h83
`define CSR_PSW_ADDR   8'hd0
`define CSR_ACC_ADDR   8'he0
`define CSR_B_ADDR     8'hf0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CSR_SP_RESET   8'h07
`define CSR_DP_RESET   8'h00
`define CSR_PSW_RESET  8'h00
`define CSR_ACC_RESET  8'h00
`define CSR_B_RESET    8'h00

// ----------------------------------------
// Status word fields
// ----------------------------------------
`define CSR_CY_BIT     7
`define CSR_AC_BIT     6
`define CSR_F0_BIT     5
`define CSR_RS_HI      4
`define CSR_RS_LO      3
`define CSR_OV_BIT     2
`define CSR_F1_BIT     1
`define CSR_PAR_BIT    0
`define CSR_PSW_WMASK  8'hfe

`endif

// >>> csr_pkg.sv
// Types shared by the core status register block
package csr_pkg;

    // Arithmetic operations that touch the flags, plus the idle CSR_OP_NONE
    typedef enum logic [2:0] {
        CSR_OP_NONE,
        CSR_OP_SUM,
        CSR_OP_SUM_CARRY,
        CSR_OP_DIFF_BORROW,
        CSR_OP_PRODUCT,
        CSR_OP_QUOTIENT
    } csr_op_e;

endpackage

// >>> csr_alu_if.sv
// Carrier between the register core and its arithmetic unit
`timescale 1ns/100ps
`default_nettype none
interface csr_alu_if;
    import csr_pkg::*;
    csr_op_e    op;
    logic [7:0] acc;
    logic [7:0] b;
    logic [7:0] operand;
    logic       carry_in;
    logic [7:0] res_acc;
    logic [7:0] res_b;
    logic       write_acc;
    logic       write_b;
    logic       cy;
    logic       ac;
    logic       ov;
    logic       upd_cy_ac;
    logic       upd_ov;

    modport core (output op, acc, b, operand, carry_in,
                  input  res_acc, res_b, write_acc, write_b,
                         cy, ac, ov, upd_cy_ac, upd_ov);
    modport alu  (input  op, acc, b, operand, carry_in,
                  output res_acc, res_b, write_acc, write_b,
                         cy, ac, ov, upd_cy_ac, upd_ov);
endinterface
`default_nettype wire

// >>> csr_alu.sv
// Arithmetic unit computing results and flags for the register core
`timescale 1ns/100ps
`default_nettype none
module csr_alu
    import csr_pkg::*;
(
    csr_alu_if.alu a
);

    // Signed overflow: add overflows when like signs give an unlike sign
    function automatic logic csr_sovf(input logic x,
                                      input logic y,
                                      input logic r,
                                      input logic sub);
        csr_sovf = sub ? ((x != y) && (r != x)) : ((x == y) && (r != x));
    endfunction

    logic [8:0]  sum9;
    logic [4:0]  nib5;
    logic [15:0] prod;
    logic        cin;

    // Carry only feeds the carrying forms
    assign cin  = (a.op == CSR_OP_SUM) ? 1'b0 : a.carry_in;
    assign prod = {8'h00, a.acc} * {8'h00, a.b};

    // Result and flag selection per operation
    always_comb
    begin
        sum9        = 9'h000;
        nib5        = 5'h00;
        a.res_acc   = a.acc;
        a.res_b     = a.b;
        a.write_acc = 1'b0;
        a.write_b   = 1'b0;
        a.cy        = 1'b0;
        a.ac        = 1'b0;
        a.ov        = 1'b0;
        a.upd_cy_ac = 1'b0;
        a.upd_ov    = 1'b0;
        unique case (a.op)
            CSR_OP_NONE:
            begin
            end
            CSR_OP_SUM, CSR_OP_SUM_CARRY:
            begin
                sum9 = {1'b0, a.acc} + {1'b0, a.operand} + {8'h00, cin};
                nib5 = {1'b0, a.acc[3:0]} + {1'b0, a.operand[3:0]}
                     + {4'h0, cin};
                a.res_acc   = sum9[7:0];
                a.write_acc = 1'b1;
                a.cy        = sum9[8];
                a.ac        = nib5[4];
                a.ov        = csr_sovf(a.acc[7], a.operand[7],
                                       sum9[7], 1'b0);
                a.upd_cy_ac = 1'b1;
                a.upd_ov    = 1'b1;
            end
            CSR_OP_DIFF_BORROW:
            begin
                sum9 = {1'b0, a.acc} - {1'b0, a.operand} - {8'h00, cin};
                nib5 = {1'b0, a.acc[3:0]} - {1'b0, a.operand[3:0]}
                     - {4'h0, cin};
                a.res_acc   = sum9[7:0];
                a.write_acc = 1'b1;
                a.cy        = sum9[8];
                a.ac        = nib5[4];
                a.ov        = csr_sovf(a.acc[7], a.operand[7],
                                       sum9[7], 1'b1);
                a.upd_cy_ac = 1'b1;
                a.upd_ov    = 1'b1;
            end
            CSR_OP_PRODUCT:
            begin
                a.res_acc   = prod[7:0];
                a.res_b     = prod[15:8];
                a.write_acc = 1'b1;
                a.write_b   = 1'b1;
                a.ov        = (prod[15:8] != 8'h00);
                a.upd_cy_ac = 1'b1;         // Cleared
                a.upd_ov    = 1'b1;
            end
            CSR_OP_QUOTIENT:
            begin
                // Zero divisor leaves both operands untouched
                if (a.b != 8'h00)
                begin
                    a.res_acc   = a.acc / a.b;
                    a.res_b     = a.acc % a.b;
                    a.write_acc = 1'b1;
                    a.write_b   = 1'b1;
                end
                a.ov        = (a.b == 8'h00);
                a.upd_cy_ac = 1'b1;
                a.upd_ov    = 1'b1;
            end
            default:
            begin
            end
        endcase
    end

endmodule
`default_nettype wire

// >>> csr_core.sv
// Core status registers: stack pointer, data pointer, status, operands
`timescale 1ns/100ps
`default_nettype none
`include "csr_params.svh"
module csr_core
    import csr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    output logic             sfr_hit,
    input  wire logic [7:0]  bit_addr,
    input  wire logic        bit_wr,
    input  wire logic        bit_rd,
    input  wire logic        bit_wdata,
    output logic             bit_rdata,
    input  wire logic        op_valid,
    input  wire csr_op_e     op_code,
    input  wire logic [7:0]  op_operand,
    input  wire logic        push_req,
    input  wire logic [7:0]  push_data,
    input  wire logic        pop_req,
    output logic             stack_wr_en,
    output logic      [7:0]  stack_wr_addr,
    output logic      [7:0]  stack_wr_data,
    output logic      [7:0]  stack_rd_addr,
    output logic      [7:0]  stack_pointer,
    output logic      [15:0] indirect_pointer,
    output logic      [4:0]  bank_base,
    output logic      [7:0]  status_word,
    output logic      [7:0]  accumulator,
    output logic      [7:0]  second_operand
);

    // Software value of a register after a byte or single-bit write
    function automatic logic [7:0] csr_sw_value(input logic [7:0] cur,
                                                input logic       by_wr,
                                                input logic       bt_wr,
                                                input logic [7:0] wd,
                                                input logic [2:0] bsel,
                                                input logic       bval);
        logic [7:0] v;
        v = cur;
        if (by_wr)
            v = wd;
        else if (bt_wr)
            v[bsel] = bval;
        csr_sw_value = v;
    endfunction

    logic [7:0] sp_reg;
    logic [7:0] sp_next;
    logic [7:0] dpl_reg;
    logic [7:0] dph_reg;
    logic [7:0] psw_reg;
    logic [7:0] psw_next;
    logic [7:0] acc_reg;
    logic [7:0] acc_next;
    logic [7:0] b_reg;
    logic [7:0] b_next;
    logic       swr_en_reg;
    logic [7:0] swr_addr_reg;
    logic [7:0] swr_data_reg;
    logic [7:0] rdata_reg;
    logic       hit_reg;
    logic       bitq_reg;

    csr_alu_if alu_bus ();

    csr_alu u_alu (
        .a (alu_bus.alu)
    );

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // Below 0x80 the direct space is data memory, so it never decodes here
    wire logic       sfr_space = sfr_addr[7];
    wire logic       bit_space = bit_addr[7];
    // A bit address always names a byte ending in 0x0 or 0x8
    wire logic [7:0] bit_byte  = {bit_addr[7:3], 3'b000};
    wire logic       wr_sp     = sfr_wr & sfr_space
                               & (sfr_addr == `CSR_SP_ADDR);
    wire logic       wr_dpl    = sfr_wr & sfr_space
                               & (sfr_addr == `CSR_DPL_ADDR);
    wire logic       wr_dph    = sfr_wr & sfr_space
                               & (sfr_addr == `CSR_DPH_ADDR);
    wire logic       wr_psw    = sfr_wr & sfr_space
                               & (sfr_addr == `CSR_PSW_ADDR);
    wire logic       wr_acc    = sfr_wr & sfr_space
                               & (sfr_addr == `CSR_ACC_ADDR);
    wire logic       wr_b      = sfr_wr & sfr_space
                               & (sfr_addr == `CSR_B_ADDR);
    wire logic       bw_psw    = bit_wr & bit_space
                               & (bit_byte == `CSR_PSW_ADDR);
    wire logic       bw_acc    = bit_wr & bit_space
                               & (bit_byte == `CSR_ACC_ADDR);
    wire logic       bw_b      = bit_wr & bit_space
                               & (bit_byte == `CSR_B_ADDR);

    // Parity is live from the accumulator, never stored
    wire logic       parity    = ^acc_reg;
    wire logic [7:0] psw_view  = {psw_reg[7:1], parity};

    // ----------------------------------------
    // Read selection
    // ----------------------------------------
    wire logic       sfr_map   = sfr_space & (
                                 (sfr_addr == `CSR_SP_ADDR)
                               | (sfr_addr == `CSR_DPL_ADDR)
                               | (sfr_addr == `CSR_DPH_ADDR)
                               | (sfr_addr == `CSR_PSW_ADDR)
                               | (sfr_addr == `CSR_ACC_ADDR)
                               | (sfr_addr == `CSR_B_ADDR));
    wire logic [7:0] sfr_sel   =
        !sfr_space                    ? 8'h00    :
        (sfr_addr == `CSR_SP_ADDR)    ? sp_reg   :
        (sfr_addr == `CSR_DPL_ADDR)   ? dpl_reg  :
        (sfr_addr == `CSR_DPH_ADDR)   ? dph_reg  :
        (sfr_addr == `CSR_PSW_ADDR)   ? psw_view :
        (sfr_addr == `CSR_ACC_ADDR)   ? acc_reg  :
        (sfr_addr == `CSR_B_ADDR)     ? b_reg    : 8'h00;
    wire logic       bit_map   = bit_space & (
                                 (bit_byte == `CSR_PSW_ADDR)
                               | (bit_byte == `CSR_ACC_ADDR)
                               | (bit_byte == `CSR_B_ADDR));
    wire logic [7:0] bit_src   =
        !bit_space                    ? 8'h00    :
        (bit_byte == `CSR_PSW_ADDR)   ? psw_view :
        (bit_byte == `CSR_ACC_ADDR)   ? acc_reg  :
        (bit_byte == `CSR_B_ADDR)     ? b_reg    : 8'h00;

    // ----------------------------------------
    // Arithmetic unit hookup
    // ----------------------------------------
    assign alu_bus.op       = op_valid ? op_code : CSR_OP_NONE;
    assign alu_bus.acc      = acc_reg;
    assign alu_bus.b        = b_reg;
    assign alu_bus.operand  = op_operand;
    assign alu_bus.carry_in = psw_reg[`CSR_CY_BIT];

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    // Push beats pop and software so the top of stack stays coherent
    always_comb
    begin
        if (push_req)
            sp_next = sp_reg + 8'h01;
        else if (pop_req)
            sp_next = sp_reg - 8'h01;
        else if (wr_sp)
            sp_next = sfr_wdata;
        else
            sp_next = sp_reg;
    end

    // Hardware flags overwrite whatever software wrote this cycle
    always_comb
    begin
        psw_next = csr_sw_value(psw_view, wr_psw, bw_psw, sfr_wdata,
                                bit_addr[2:0], bit_wdata)
                 & `CSR_PSW_WMASK;
        if (alu_bus.upd_cy_ac)
        begin
            psw_next[`CSR_CY_BIT] = alu_bus.cy;
            psw_next[`CSR_AC_BIT] = alu_bus.ac;
        end
        if (alu_bus.upd_ov)
            psw_next[`CSR_OV_BIT] = alu_bus.ov;
    end

    // Operand registers: an executing operation wins over software
    assign acc_next = alu_bus.write_acc ? alu_bus.res_acc
                    : csr_sw_value(acc_reg, wr_acc, bw_acc, sfr_wdata,
                                   bit_addr[2:0], bit_wdata);
    assign b_next   = alu_bus.write_b ? alu_bus.res_b
                    : csr_sw_value(b_reg, wr_b, bw_b, sfr_wdata,
                                   bit_addr[2:0], bit_wdata);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Architectural state
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sp_reg  <= `CSR_SP_RESET;
            dpl_reg <= `CSR_DP_RESET;
            dph_reg <= `CSR_DP_RESET;
            psw_reg <= `CSR_PSW_RESET;
            acc_reg <= `CSR_ACC_RESET;
            b_reg   <= `CSR_B_RESET;
        end
        else
        begin
            sp_reg  <= sp_next;
            dpl_reg <= wr_dpl ? sfr_wdata : dpl_reg;
            dph_reg <= wr_dph ? sfr_wdata : dph_reg;
            psw_reg <= psw_next;
            acc_reg <= acc_next;
            b_reg   <= b_next;
        end
    end

    // Stack write lands one cycle after the increment, at the new top
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            swr_en_reg   <= 1'b0;
            swr_addr_reg <= 8'h00;
            swr_data_reg <= 8'h00;
        end
        else
        begin
            swr_en_reg   <= push_req;
            swr_addr_reg <= push_req ? sp_next : swr_addr_reg;
            swr_data_reg <= push_req ? push_data : swr_data_reg;
        end
    end

    // Read data are registered and hold until the next read; the hit flag is not held and is high in the cycle after each mapped read
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rdata_reg <= 8'h00;
            hit_reg   <= 1'b0;
            bitq_reg  <= 1'b0;
        end
        else
        begin
            rdata_reg <= sfr_rd ? sfr_sel : rdata_reg;
            bitq_reg  <= bit_rd ? bit_src[bit_addr[2:0]] : bitq_reg;
            hit_reg   <= (sfr_rd & sfr_map) | (bit_rd & bit_map);
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign sfr_rdata        = rdata_reg;
    assign sfr_hit          = hit_reg;
    assign bit_rdata        = bitq_reg;
    assign stack_wr_en      = swr_en_reg;
    assign stack_wr_addr    = swr_addr_reg;
    assign stack_wr_data    = swr_data_reg;
    assign stack_rd_addr    = sp_reg;       // Pop reads the top, then drops
    assign stack_pointer    = sp_reg;
    assign indirect_pointer = {dph_reg, dpl_reg};
    // Bank n starts at 8n
    assign bank_base        = {psw_reg[`CSR_RS_HI:`CSR_RS_LO], 3'b000};
    assign status_word      = psw_view;
    assign accumulator      = acc_reg;
    assign second_operand   = b_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic [8:0]  chk_sum;
    logic [15:0] chk_prod;
    assign chk_sum  = {1'b0, acc_reg} + {1'b0, op_operand};
    assign chk_prod = {8'h00, acc_reg} * {8'h00, b_reg};

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_push;
        push_req;
    endsequence
    sequence s_store_at_top;
        stack_wr_en && (stack_wr_addr == stack_pointer);
    endsequence

    AST_SP_RESET:
        assert property ($past(reset) |-> stack_pointer == `CSR_SP_RESET)
        else $error("stack pointer not at reset value");
    AST_PUSH_ORDER:
        assert property (s_push |=> s_store_at_top
                         and (stack_pointer == $past(stack_pointer) + 8'h01))
        else $error("push did not increment before storing");
    AST_PTR_HIGH:
        assert property (wr_dph |=> indirect_pointer[15:8] == $past(sfr_wdata))
        else $error("pointer high byte not in bits 15-8");
    AST_CARRY_SUM:
        assert property (op_valid && op_code == CSR_OP_SUM && !wr_psw
                         |=> status_word[`CSR_CY_BIT] == $past(chk_sum[8]))
        else $error("carry wrong after add");
    AST_PRODUCT_CLEAR:
        assert property (op_valid && op_code == CSR_OP_PRODUCT
                         |=> !status_word[`CSR_CY_BIT]
                             && !status_word[`CSR_AC_BIT])
        else $error("carry flags not cleared by product");
    AST_USER_FLAGS:
        assert property (!wr_psw && !bw_psw
                         |=> $stable(status_word[`CSR_F0_BIT])
                             && $stable(status_word[`CSR_F1_BIT]))
        else $error("user flag changed without software");
    AST_BANK:
        assert property (wr_psw && !op_valid |=> bank_base ==
                         {$past(sfr_wdata[`CSR_RS_HI:`CSR_RS_LO]), 3'b000})
        else $error("bank base does not follow select bits");
    AST_DIV_ZERO:
        assert property (op_valid && op_code == CSR_OP_QUOTIENT
                         && b_reg == 8'h00
                         |=> status_word[`CSR_OV_BIT]
                             && accumulator == $past(accumulator))
        else $error("divide by zero not flagged");
    AST_OV_CLEAR:
        assert property (op_valid && op_code == CSR_OP_PRODUCT
                         && chk_prod[15:8] == 8'h00
                         |=> !status_word[`CSR_OV_BIT])
        else $error("overflow not cleared by small product");
    AST_PARITY_READ:
        assert property (sfr_rd && sfr_addr == `CSR_PSW_ADDR
                         |=> sfr_rdata[`CSR_PAR_BIT] == ^$past(accumulator))
        else $error("parity read wrong");
    AST_LOW_SPACE:
        assert property (sfr_rd && !sfr_addr[7] && !bit_rd
                         |=> !sfr_hit && sfr_rdata == 8'h00)
        else $error("low direct address answered");
    AST_HW_WINS:
        assert property (op_valid && op_code == CSR_OP_SUM && wr_psw
                         |=> status_word[`CSR_CY_BIT] == $past(chk_sum[8]))
        else $error("software write beat hardware carry");

endmodule
`default_nettype wire

// >>> core_status_registers_bench.sv
// Self-checking bench for the core status register block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    bad_count++; $display("Error %s expected %h seen %h", nm, ex, got); \
    end end
module core_status_registers_bench
    import csr_pkg::*;
();
    logic        clk, reset, sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata;
    logic        op_valid, push_req, pop_req, sfr_hit, bit_rdata;
    logic        stack_wr_en;
    logic [7:0]  sfr_addr, sfr_wdata, bit_addr, op_operand, push_data;
    logic [7:0]  sfr_rdata, stack_wr_addr, stack_wr_data, stack_rd_addr;
    logic [7:0]  stack_pointer, status_word, accumulator, second_operand;
    logic [15:0] indirect_pointer;
    logic [4:0]  bank_base;
    csr_op_e     op_code;
    logic [7:0]  m_acc, m_sec, m_psw, x, y;
    int          bad_count, n_checks;

    csr_core dut_u (.*);

    // Free-running 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Watchdog: the whole run needs well under 2000 cycles
    initial
    begin
        #200000;
        bad_count++;
        end_of_test();
    end

    // ----------------------------------------
    // Reference model and bus tasks
    // ----------------------------------------
    // Returns {acc, second, carry, half carry, overflow}
    function automatic logic [18:0] model(input logic [2:0] k,
        input logic [7:0] a, s, o, input logic c);
        logic [8:0] r;
        logic [15:0] p;
        logic h, v;
        p = a * s;
        if (k == 3'd4)
            return {p[7:0], p[15:8], 2'b00, p[15:8] != 8'h00};
        if (k == 3'd5)
            return (s == 8'h00) ? {a, s, 3'b001} : {a / s, a % s, 3'b000};
        c = (k == 3'd1) ? 1'b0 : c;
        if (k == 3'd3)
        begin
            r = {1'b0, a} - {1'b0, o} - {8'h00, c};
            h = {1'b0, a[3:0]} < ({1'b0, o[3:0]} + {4'h0, c});
            v = (a[7] != o[7]) && (r[7] != a[7]);
        end
        else
        begin
            r = {1'b0, a} + {1'b0, o} + {8'h00, c};
            h = ({1'b0, a[3:0]} + {1'b0, o[3:0]} + {4'h0, c}) > 5'h0f;
            v = (a[7] == o[7]) && (r[7] != a[7]);
        end
        return {r[7:0], s, r[8], h, v};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge clk);
        sfr_wr <= 1'b0;
        #1;
    endtask

    // Read answer lands one cycle after the request is taken
    task automatic rd(input logic [7:0] a, input logic [7:0] ex,
        input logic hit);
        @(posedge clk);
        sfr_rd <= 1'b1;
        sfr_addr <= a;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1;
        `CHK("read data", ex, sfr_rdata)
        `CHK("read hit", hit, sfr_hit)
    endtask

    // Optional same-cycle status write shows hardware flags winning
    task automatic do_op(input logic [2:0] k, input logic [7:0] o,
        input logic sw);
        logic [18:0] r;
        r = model(k, m_acc, m_sec, o, m_psw[7]);
        @(posedge clk);
        op_valid <= 1'b1;
        op_code <= csr_op_e'(k);
        op_operand <= o;
        sfr_wr <= sw;
        sfr_addr <= 8'hd0;
        sfr_wdata <= m_psw | 8'hc4;
        @(posedge clk);
        op_valid <= 1'b0;
        sfr_wr <= 1'b0;
        {m_acc, m_sec} = r[18:3];
        m_psw = {r[2:1], m_psw[5:3], r[0], m_psw[1], ^m_acc};
        #1;
        `CHK("accumulator", m_acc, accumulator)
        `CHK("second", m_sec, second_operand)
        `CHK("status", m_psw, status_word)
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {reset, sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata} = 6'h20;
        {op_valid, push_req, pop_req} = 3'h0;
        {sfr_addr, sfr_wdata, bit_addr, op_operand, push_data} = 40'h0;
        op_code = CSR_OP_NONE;
        {m_acc, m_sec, m_psw, bad_count, n_checks} = '0;
        x = 8'($urandom(19280));
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        rd(8'h81, 8'h07, 1'b1);
        rd(8'he0, 8'h00, 1'b1);
        rd(8'hf0, 8'h00, 1'b1);
        // Reserved locations only ever get zeros
        wr(8'h84, 8'h00);
        rd(8'h84, 8'h00, 1'b0);
        $display("reset and decode test done");
        // Back-to-back pushes, then a pop
        @(posedge clk);
        push_req <= 1'b1;
        push_data <= 8'ha5;
        @(posedge clk);
        push_data <= 8'h3c;
        #1 `CHK("push address", 8'h08, stack_wr_addr)
        `CHK("push strobe", 1'b1, stack_wr_en)
        @(posedge clk);
        {push_req, pop_req} <= 2'b01;
        #1 `CHK("push data", 8'h3c, stack_wr_data)
        `CHK("stack top", 8'h09, stack_pointer)
        @(posedge clk);
        pop_req <= 1'b0;
        #1 `CHK("after pop", 8'h08, stack_pointer)
        `CHK("pop address", 8'h08, stack_rd_addr)
        `CHK("strobe drop", 1'b0, stack_wr_en)
        $display("stack test done");
        repeat (4)
        begin
            {x, y} = 16'($urandom);
            wr(8'h82, x);
            wr(8'h83, y);
            `CHK("pointer", {y, x}, indirect_pointer)
        end
        // Idle cycles follow every bank change
        for (int n = 0; n < 4; n++)
        begin
            wr(8'hd0, 8'(n << 3));
            `CHK("bank base", 5'(n << 3), bank_base)
        end
        // Set the upper user flag by bit access, read it back
        @(posedge clk);
        {bit_wr, bit_wdata, bit_addr} <= {2'b11, 8'hd5};
        @(posedge clk);
        {bit_wr, bit_rd} <= 2'b01;
        @(posedge clk);
        bit_rd <= 1'b0;
        #1 `CHK("user flag", 1'b1, bit_rdata)
        m_psw = 8'h38;
        $display("pointer and bank test done");
        wr(8'he0, 8'hff);
        m_acc = 8'hff;
        do_op(3'd1, 8'h01, 1'b1);
        do_op(3'd5, 8'h00, 1'b0);
        for (int i = 0; i < 40; i++)
        begin
            {x, y} = 16'($urandom);
            wr(8'he0, x);
            wr(8'hf0, (i % 6 == 0) ? 8'h00 : y);
            {m_acc, m_sec} = {x, (i % 6 == 0) ? 8'h00 : y};
            do_op(3'(1 + i % 5), 8'($urandom), i % 4 == 0);
        end
        $display("arithmetic test done");
        end_of_test();
    end
endmodule
`default_nettype wire
